// >>> rtl/usrx_receiver.sv
// Serial receive block: start detection, majority voting, two-entry receive
// buffer with per-character status, and the register port.
// Assumes a one-cycle oversampling tick from an outside baud divider and a
// receive line already synchronous to the core clock.
`timescale 1ns/1ns
module usrx_receiver #(
    parameter int DEPTH = usrx_pkg::BUF_DEPTH
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_sample_tick,
    input  wire logic       i_rx_line,
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    output logic            o_rx_irq,
    output logic            o_pin_override
);

    // Head, pop and push indexing serve exactly two entries
    if (DEPTH != 2) begin : g_depth_check
        $error("usrx_receiver: buffer depth must be 2");
    end

    typedef enum logic [1:0] {USRX_IDLE, USRX_START, USRX_BITS} usrx_state_t;

    // Register state
    logic [7:0]  ctrl_b_reg, ctrl_b_next;
    logic [7:0]  ctrl_c_reg, ctrl_c_next;
    logic        u2x_reg, u2x_next;
    logic [7:0]  rdata_reg, rdata_next;
    logic        irq_reg, irq_next;
    logic        ovr_pend_reg, ovr_pend_next;

    // Buffer entry: {pe, ovr, fe, bit8, data[7:0]}
    logic [11:0] buf_reg [DEPTH];
    logic [11:0] buf_next [DEPTH];
    logic [1:0]  cnt_reg, cnt_next;

    // Shift register and its waiting character
    logic [11:0] shf_hold_reg, shf_hold_next;
    logic        shf_full_reg, shf_full_next;

    // Receive engine
    usrx_state_t st_reg, st_next;
    logic [3:0]  smp_reg, smp_next;
    logic [3:0]  bitn_reg, bitn_next;
    logic [1:0]  ones_reg, ones_next;
    logic [9:0]  sh_reg, sh_next;
    logic        line_prev_reg, line_prev_next;

    // Decoded configuration
    logic        rx_en;
    logic        pen;
    logic [2:0]  sz;
    logic [3:0]  nbits;
    logic [3:0]  spb_last;
    logic [3:0]  vote_lo;
    logic [3:0]  frame_bits;
    logic [7:0]  data_mask;

    always_comb begin
        rx_en      = ctrl_b_reg[usrx_pkg::CB_RECEIVER_ENABLE_BIT];
        pen        = ctrl_c_reg[usrx_pkg::CC_PEN];
        sz         = {ctrl_b_reg[usrx_pkg::CB_SZ2], ctrl_c_reg[usrx_pkg::CC_SZ1],
                      ctrl_c_reg[usrx_pkg::CC_SZ0]};
        // Reserved size codes fall back to eight bits
        nbits      = (sz == usrx_pkg::SZ_NINE) ? 4'h9
                   : ((sz[2] == 1'b1) ? 4'h8 : 4'(sz[1:0]) + 4'h5);
        // Frame bits after start: data, optional parity, first stop only
        frame_bits = nbits + 4'(pen) + 4'h1;
        spb_last   = u2x_reg ? usrx_pkg::SPB_D : usrx_pkg::SPB_N;
        vote_lo    = u2x_reg ? usrx_pkg::VOTE_D_LO : usrx_pkg::VOTE_N_LO;
        data_mask  = 8'hFF >> (4'h8 - ((nbits > 4'h8) ? 4'h8 : nbits));
    end

    // Vote window helpers, counted from sample one of each bit
    // While smp_reg holds k the tick takes sample k plus one
    logic in_vote;
    logic vote_end;
    logic vote_bit;

    always_comb begin
        in_vote  = (smp_reg >= vote_lo) && (smp_reg <= vote_lo + 4'h2);
        vote_end = (smp_reg == vote_lo + 4'h2);
        // Majority of the three centre samples, current one included
        vote_bit = ((2'(ones_reg) + 2'(i_rx_line)) >= 2'h2);
    end

    // Framing of a finished character
    logic [11:0] new_char;
    logic        par_calc;
    logic        par_bit;
    logic        stop_bit;
    // Room for nine data bits plus the parity bit
    logic [9:0]  dbits;
    logic        done_now;

    always_comb begin
        // Shift register holds received bits LSB first, final stop voted now
        dbits    = sh_reg >> (4'd10 - (frame_bits - 4'h1));
        stop_bit = vote_bit;
        // Parity sits just above the data, bit nine for nine-bit characters
        par_bit  = dbits[nbits];
        par_calc = ^(dbits & ((10'h001 << nbits) - 10'h001))
                   ^ ctrl_c_reg[usrx_pkg::CC_PTYPE];
        new_char = {pen & (par_calc != par_bit),
                    1'b0,
                    ~stop_bit,
                    (nbits == 4'h9) ? dbits[8] : 1'b0,
                    dbits[7:0] & data_mask};
        if (!pen) begin
            par_bit = 1'b0;
        end
        done_now = (st_reg == USRX_BITS) && i_sample_tick && vote_end
                   && (bitn_reg == frame_bits - 4'h1);
    end

    // Receive engine next state
    logic start_ok;

    always_comb begin
        st_next        = st_reg;
        smp_next       = smp_reg;
        bitn_next      = bitn_reg;
        ones_next      = ones_reg;
        sh_next        = sh_reg;
        line_prev_next = line_prev_reg;
        start_ok       = 1'b0;
        // History follows every tick, so enabling on a low line gives no edge
        if (i_sample_tick) begin
            line_prev_next = i_rx_line;
        end
        if (!rx_en) begin
            st_next  = USRX_IDLE;
            smp_next = 4'h0;
        end else if (i_sample_tick) begin
            case (st_reg)
                USRX_IDLE: begin
                    // Falling edge on an idle line gives sample one
                    if (line_prev_reg && !i_rx_line) begin
                        st_next   = USRX_START;
                        smp_next  = 4'h1;
                        ones_next = 2'h0;
                    end
                end
                USRX_START: begin
                    smp_next = smp_reg + 4'h1;
                    if (in_vote) begin
                        ones_next = ones_reg + 2'(i_rx_line);
                    end
                    if (vote_end) begin
                        if (vote_bit) begin
                            st_next = USRX_IDLE;
                        end else begin
                            start_ok = 1'b1;
                        end
                    end
                    // In normal mode spb_last + 1 wraps to zero with the four-bit
                    // count, so both modes still see a full bit of ticks
                    if (smp_reg == spb_last + 4'h1) begin
                        // Bit boundary: data recovery begins
                        st_next   = USRX_BITS;
                        smp_next  = 4'h1;
                        bitn_next = 4'h0;
                        ones_next = 2'h0;
                    end
                end
                USRX_BITS: begin
                    smp_next = (smp_reg == spb_last + 4'h1) ? 4'h1 : smp_reg + 4'h1;
                    if (smp_reg == spb_last + 4'h1) begin
                        ones_next = 2'h0;
                    end else if (in_vote) begin
                        ones_next = ones_reg + 2'(i_rx_line);
                    end
                    if (vote_end) begin
                        sh_next   = {vote_bit, sh_reg[9:1]};
                        bitn_next = bitn_reg + 4'h1;
                        if (done_now) begin
                            // Next start may follow right after the stop vote
                            st_next = USRX_IDLE;
                        end
                    end
                end
                default: begin
                    st_next = USRX_IDLE;
                end
            endcase
        end
    end

    // Buffer, shift-hold, overrun and register port next state
    logic        rd_data;
    logic [11:0] head;
    logic [11:0] push_char;
    logic        push;
    logic [1:0]  cnt_pop;

    always_comb begin
        ctrl_b_next   = ctrl_b_reg;
        ctrl_c_next   = ctrl_c_reg;
        u2x_next      = u2x_reg;
        cnt_next      = cnt_reg;
        buf_next      = buf_reg;
        shf_hold_next = shf_hold_reg;
        shf_full_next = shf_full_reg;
        ovr_pend_next = ovr_pend_reg;
        rdata_next    = 8'h00;
        push          = 1'b0;
        push_char     = shf_hold_reg;
        head          = (cnt_reg != 2'h0) ? buf_reg[0] : 12'h000;
        // A data read while disabled still answers the head but never pops
        rd_data       = i_rd && (i_addr == usrx_pkg::OFS_DATA) && rx_en;

        // Register reads answer one cycle later
        if (i_rd) begin
            case (i_addr)
                usrx_pkg::OFS_DATA:   rdata_next = head[7:0];
                usrx_pkg::OFS_STATUS: rdata_next = {(cnt_reg != 2'h0), 2'b00, head[9],
                                                    head[10], head[11], u2x_reg,
                                                    1'b0};
                usrx_pkg::OFS_CTRL_B: rdata_next = {ctrl_b_reg[7:2], head[8],
                                                    1'b0};
                usrx_pkg::OFS_CTRL_C: rdata_next = ctrl_c_reg;
                default:              rdata_next = 8'h00;
            endcase
        end

        // Writes; error flag positions in status are not writable
        if (i_wr) begin
            case (i_addr)
                usrx_pkg::OFS_STATUS: u2x_next = i_wdata[usrx_pkg::STS_U2X];
                usrx_pkg::OFS_CTRL_B: ctrl_b_next = {i_wdata[7:2], 1'b0, 1'b0};
                usrx_pkg::OFS_CTRL_C: ctrl_c_next = i_wdata;
                default: ;
            endcase
        end

        // Pop on data read advances the head
        cnt_pop = cnt_reg;
        if (rd_data && cnt_reg != 2'h0) begin
            buf_next[0] = buf_reg[1];
            cnt_pop     = cnt_reg - 2'h1;
        end
        cnt_next = cnt_pop;

        // Finished frame enters the hold slot of the shift register
        if (done_now) begin
            shf_hold_next = new_char;
            shf_full_next = 1'b1;
        end

        // Overrun: full buffer, waiting character, new start qualified
        // A data read in the same cycle frees a slot, so nothing is lost then
        if (start_ok && shf_full_reg && cnt_reg == 2'(DEPTH) && !rd_data) begin
            shf_full_next = 1'b0;
            ovr_pend_next = 1'b1;
        end

        // Move waiting character into the buffer when room exists
        // A frame finishing now refills the hold slot at once
        if (shf_full_reg && cnt_pop != 2'(DEPTH)
                && !(start_ok && cnt_reg == 2'(DEPTH) && !rd_data)) begin
            push          = 1'b1;
            push_char     = {shf_hold_reg[11], ovr_pend_reg, shf_hold_reg[9:0]};
            buf_next[cnt_pop[0]] = push_char;
            cnt_next      = cnt_pop + 2'h1;
            ovr_pend_next = 1'b0;
            shf_full_next = done_now;
        end

        // Disable flushes everything at once
        // Flush wins over any push or pop in the same cycle
        if (!rx_en) begin
            cnt_next      = 2'h0;
            shf_full_next = 1'b0;
            ovr_pend_next = 1'b0;
        end
    end

    // Interrupt level from receive-complete only; error flags never feed it
    always_comb begin
        irq_next = ctrl_b_next[usrx_pkg::CB_RECEIVE_COMPLETE_IRQ_ENABLE] && (cnt_next != 2'h0);
    end

    // Registers
    // Line history resets high so no false start follows reset
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_b_reg    <= usrx_pkg::RST_CTRL_B;
            ctrl_c_reg    <= usrx_pkg::RST_CTRL_C;
            u2x_reg       <= usrx_pkg::RST_U2X;
            rdata_reg     <= 8'h00;
            irq_reg       <= 1'b0;
            ovr_pend_reg  <= 1'b0;
            cnt_reg       <= 2'h0;
            shf_hold_reg  <= 12'h000;
            shf_full_reg  <= 1'b0;
            st_reg        <= USRX_IDLE;
            smp_reg       <= 4'h0;
            bitn_reg      <= 4'h0;
            ones_reg      <= 2'h0;
            sh_reg        <= 10'h000;
            line_prev_reg <= 1'b1;
        end else begin
            ctrl_b_reg    <= ctrl_b_next;
            ctrl_c_reg    <= ctrl_c_next;
            u2x_reg       <= u2x_next;
            rdata_reg     <= rdata_next;
            irq_reg       <= irq_next;
            ovr_pend_reg  <= ovr_pend_next;
            cnt_reg       <= cnt_next;
            shf_hold_reg  <= shf_hold_next;
            shf_full_reg  <= shf_full_next;
            st_reg        <= st_next;
            smp_reg       <= smp_next;
            bitn_reg      <= bitn_next;
            ones_reg      <= ones_next;
            sh_reg        <= sh_next;
            line_prev_reg <= line_prev_next;
        end
    end

    // Buffer storage, one flip-flop word per entry
    for (genvar g = 0; g < DEPTH; g++) begin : g_buf
        always_ff @(posedge i_core_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                buf_reg[g] <= 12'h000;
            end else begin
                buf_reg[g] <= buf_next[g];
            end
        end
    end

    // Pin override follows the enable bit directly
    // Taken from the next value so the pin moves one cycle after the write, with the enable bit
    logic ovr_pin_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovr_pin_reg <= 1'b0;
        end else begin
            ovr_pin_reg <= ctrl_b_next[usrx_pkg::CB_RECEIVER_ENABLE_BIT];
        end
    end

    assign o_rdata        = rdata_reg;
    assign o_rx_irq       = irq_reg;
    assign o_pin_override = ovr_pin_reg;

endmodule

// >>> rtl/usrx_pkg.sv
// Package for the serial receive block: register offsets, field positions,
// reset values and oversampling constants.
// Assumes a plain address/strobe register port and one core clock.
package usrx_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] OFS_DATA   = 2'h0;
    localparam logic [1:0] OFS_STATUS = 2'h1;
    localparam logic [1:0] OFS_CTRL_B = 2'h2;
    localparam logic [1:0] OFS_CTRL_C = 2'h3;

    // Status register bit positions
    localparam int STS_RXC = 7;
    localparam int STS_FE  = 4;
    localparam int STS_OVR = 3;
    localparam int STS_PE  = 2;
    localparam int STS_U2X = 1;

    // Control register B bit positions
    localparam int CB_RECEIVE_COMPLETE_IRQ_ENABLE = 7;
    localparam int CB_RECEIVER_ENABLE_BIT  = 4;
    localparam int CB_SZ2   = 2;
    localparam int CB_NINTH_RECEIVED_BIT  = 1;

    // Control register C bit positions
    localparam int CC_PEN   = 5;
    localparam int CC_PTYPE = 4;
    localparam int CC_STOP2 = 3;
    localparam int CC_SZ1   = 2;
    localparam int CC_SZ0   = 1;

    // Reset values
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [7:0] RST_CTRL_C = 8'h06;
    localparam logic       RST_U2X    = 1'b0;

    // Oversampling: samples per bit and voting window
    localparam logic [3:0] SPB_N     = 4'hF;
    localparam logic [3:0] SPB_D     = 4'h7;
    localparam logic [3:0] VOTE_N_LO = 4'h7;
    localparam logic [3:0] VOTE_D_LO = 4'h3;

    // Size code for nine-bit characters
    localparam logic [2:0] SZ_NINE = 3'h7;

    // Buffer depth in characters
    localparam int BUF_DEPTH = 2;

endpackage

// >>> tb/usrx_receiver_properties.sv
// Port checker for the serial receive block.
// Assumes shadows of software writes track the control registers.
`timescale 1ns/1ns
module usrx_receiver_properties #(
    parameter int DEPTH = 2
) (
    input wire logic       i_core_clk,
    input wire logic       i_rst_n,
    input wire logic       i_sample_tick,
    input wire logic       i_rx_line,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic       o_rx_irq,
    input wire logic       o_pin_override
);
    logic [7:0] cb_reg;
    logic [7:0] cc_reg;
    logic       u2x_reg;
    logic       sts_rd;
    default clocking dclk @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // Status read strobe, used to find the answer cycle
    assign sts_rd = i_rd && i_addr == usrx_pkg::OFS_STATUS;
    // Shadows of written values; plain flops, no next-state split needed
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cb_reg  <= usrx_pkg::RST_CTRL_B;
            cc_reg  <= usrx_pkg::RST_CTRL_C;
            u2x_reg <= usrx_pkg::RST_U2X;
        end else if (i_wr && i_addr == usrx_pkg::OFS_CTRL_B) begin
            cb_reg <= i_wdata;
        end else if (i_wr && i_addr == usrx_pkg::OFS_CTRL_C) begin
            cc_reg <= i_wdata;
        end else if (i_wr && i_addr == usrx_pkg::OFS_STATUS) begin
            u2x_reg <= i_wdata[usrx_pkg::STS_U2X];
        end
    end
    rdata_idle_a: assert property (
        !$past(i_rd) |-> o_rdata == 8'h00) else $error("read data outside answer");
    flags_empty_a: assert property (
        $past(sts_rd) && !o_rdata[usrx_pkg::STS_RXC] |-> o_rdata[4:2] == 3'b000)
        else $error("error flag with empty buffer");
    u2x_back_a: assert property (
        $past(sts_rd) |-> o_rdata[usrx_pkg::STS_U2X] == $past(u2x_reg))
        else $error("speed bit readback wrong");
    ctrlc_back_a: assert property (
        $past(i_rd && i_addr == usrx_pkg::OFS_CTRL_C)
        |-> (o_rdata & 8'h3E) == $past(cc_reg & 8'h3E)) else $error("ctrl C readback wrong");
    ctrlb_back_a: assert property (
        $past(i_rd && i_addr == usrx_pkg::OFS_CTRL_B)
        |-> (o_rdata & 8'h94) == $past(cb_reg & 8'h94)) else $error("ctrl B readback wrong");
    pin_follow_a: assert property (
        i_wr && i_addr == usrx_pkg::OFS_CTRL_B |-> ##2 o_pin_override == cb_reg[4])
        else $error("pin takeover does not follow enable");
    irq_hold_a: assert property (
        o_rx_irq && !i_rd && !i_wr && !$past(i_rd) && !$past(i_wr) |=> o_rx_irq)
        else $error("interrupt dropped without a read");
    irq_enable_a: assert property (
        !cb_reg[usrx_pkg::CB_RECEIVE_COMPLETE_IRQ_ENABLE] && !$past(cb_reg[usrx_pkg::CB_RECEIVE_COMPLETE_IRQ_ENABLE]) |-> !o_rx_irq)
        else $error("interrupt while not enabled");
    rxc_flush_a: assert property (
        $past(sts_rd) && !$past(cb_reg[4]) && !$past(cb_reg[4], 2)
        |-> !o_rdata[usrx_pkg::STS_RXC]) else $error("buffer not flushed");
    cover property ($past(sts_rd) && o_rdata[usrx_pkg::STS_OVR]);
    cover property ($past(sts_rd) && o_rdata[usrx_pkg::STS_FE]);
    cover property ($rose(o_rx_irq));
endmodule

// >>> tb/usrx_tx_model.sv
// Remote serial transmitter driving the receive line.
// Assumes i_go pulses for one cycle while o_busy is low.
`timescale 1ns/1ns
module usrx_tx_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_sample_tick,
    input  wire logic        i_go,
    input  wire logic [11:0] i_bits,
    input  wire logic [3:0]  i_nbits,
    input  wire logic [4:0]  i_spb,
    output logic             o_line,
    output logic             o_busy
);
    logic [11:0] sh;
    logic [3:0]  left;
    logic [4:0]  cnt;
    initial begin
        o_line = 1'b1;
        o_busy = 1'b0;
    end
    // Line idles high; each bit lasts i_spb ticks, changed just after a tick
    always @(posedge i_core_clk) begin
        if (i_go) begin
            sh     <= i_bits;
            left   <= i_nbits;
            cnt    <= 5'h00;
            o_busy <= 1'b1;
        end else if (o_busy && i_sample_tick && cnt != 5'h00) begin
            cnt <= cnt - 5'h01;
        end else if (o_busy && i_sample_tick && left == 4'h0) begin
            o_line <= 1'b1;
            o_busy <= 1'b0;
        end else if (o_busy && i_sample_tick) begin
            o_line <= sh[0];
            sh     <= sh >> 1;
            left   <= left - 4'h1;
            cnt    <= i_spb - 5'h01;
        end
    end
endmodule

// >>> tb/usrx_receiver_test.sv
// Self-checking bench for the serial receive block.
// Assumes a sample tick every second core cycle and a transmitter model.
`timescale 1ns/1ns
module usrx_receiver_test;
    localparam logic [1:0] DA = usrx_pkg::OFS_DATA;
    localparam logic [1:0] ST = usrx_pkg::OFS_STATUS;
    localparam logic [1:0] CB = usrx_pkg::OFS_CTRL_B;
    localparam logic [1:0] CC = usrx_pkg::OFS_CTRL_C;
    logic        clk   = 1'b0;
    logic        rst_n = 1'b0;
    logic        tick  = 1'b0;
    logic [1:0]  addr  = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        go    = 1'b0;
    logic [11:0] bits  = 12'hFFF;
    logic [3:0]  nbits = 4'h0;
    logic [4:0]  spb   = 5'h10;
    logic        line;
    logic        busy;
    logic [7:0]  rdata;
    logic        irq;
    logic        pin;
    int          bad_count  = 0;
    int          n_compared = 0;
    int          cyc        = 0;
    // Core clock, 8 ns period
    always #4 clk = ~clk;
    // Tick at half the core rate keeps frames short
    always @(posedge clk) tick <= ~tick;
    usrx_receiver usrx_receiver_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_sample_tick(tick),
        .i_rx_line(line), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .o_rx_irq(irq), .o_pin_override(pin));
    usrx_tx_model usrx_tx_model_i (.i_core_clk(clk), .i_sample_tick(tick), .i_go(go),
        .i_bits(bits), .i_nbits(nbits), .i_spb(spb), .o_line(line), .o_busy(busy));
    // Cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // Bus tasks enter just after a rising edge and leave likewise
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [1:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        // Answer stands between the two edges; look at it mid-cycle
        @(negedge clk);
        chk8(rdata, exp);
        @(posedge clk);
    endtask
    task automatic wait_idle();
        while (busy === 1'b1) @(posedge clk);
        @(posedge clk);
    endtask
    task automatic xmit(input logic [11:0] b, input logic [3:0] n, input bit hold);
        bits  <= b;
        nbits <= n;
        go    <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        if (hold) wait_idle();
    endtask
    // Eight data bits, optional parity, one stop bit
    task automatic send(input logic [7:0] d, input logic pon, input logic p, input logic stp);
        if (pon) xmit({1'b1, stp, p, d, 1'b0}, 4'hB, 1'b1);
        else xmit({2'b11, stp, d, 1'b0}, 4'hA, 1'b1);
    endtask
    task automatic t_basic();
        rdc(CB, usrx_pkg::RST_CTRL_B);
        rdc(CC, usrx_pkg::RST_CTRL_C);
        rdc(ST, 8'h00);
        wr_reg(CB, 8'h10);
        @(posedge clk);
        chk1(pin, 1'b1);
        send(8'hA5, 1'b0, 1'b0, 1'b1);
        rdc(ST, 8'h80);
        rdc(DA, 8'hA5);
        rdc(ST, 8'h00);
    endtask
    // Fourth frame starts while two are held and one waits
    task automatic t_fifo();
        send(8'h11, 1'b0, 1'b0, 1'b1);
        send(8'h22, 1'b0, 1'b0, 1'b1);
        send(8'h33, 1'b0, 1'b0, 1'b1);
        send(8'h44, 1'b0, 1'b0, 1'b1);
        rdc(ST, 8'h80);
        rdc(DA, 8'h11);
        rdc(DA, 8'h22);
        rdc(ST, 8'h88);
        rdc(DA, 8'h44);
        send(8'h3C, 1'b0, 1'b0, 1'b0);
        rdc(ST, 8'h90);
        rdc(DA, 8'h3C);
    endtask
    // Even and odd checking, each with a good and a bad parity bit
    task automatic t_parity();
        for (int i = 0; i < 4; i++) begin
            wr_reg(CC, i[1] ? 8'h36 : 8'h26);
            send(8'h5B, 1'b1, ^{8'h5B, i[1:0]}, 1'b1);
            rdc(ST, {5'h10, i[0], 2'h0});
            rdc(DA, 8'h5B);
        end
        send(8'h5B, 1'b1, 1'b1, 1'b1);
        wr_reg(CC, 8'h06);
        rdc(ST, 8'h84);
        rdc(DA, 8'h5B);
        send(8'h5B, 1'b0, 1'b0, 1'b1);
        rdc(ST, 8'h80);
        rdc(DA, 8'h5B);
        // Nine data bits, even parity over all nine
        wr_reg(CB, 8'h14);
        wr_reg(CC, 8'h26);
        xmit(12'hF4A, 4'hC, 1'b1);
        rdc(ST, 8'h80);
        rdc(CB, 8'h16);
        rdc(DA, 8'hA5);
        rdc(CB, 8'h14);
        wr_reg(CB, 8'h10);
        wr_reg(CC, 8'h06);
    endtask
    // Low pulse of 8 samples is noise, of 9 samples a start of an all-ones frame
    task automatic t_start();
        spb <= 5'h08;
        xmit(12'hFFE, 4'h1, 1'b1);
        rdc(ST, 8'h00);
        spb <= 5'h09;
        xmit(12'hFFE, 4'h1, 1'b1);
        spb <= 5'h10;
        repeat (400) @(posedge clk);
        rdc(DA, 8'hFF);
        wr_reg(CC, 8'h00);
        xmit(12'hFFE, 4'h7, 1'b1);
        rdc(DA, 8'h1F);
        wr_reg(CC, 8'h06);
        wr_reg(ST, 8'h1E);
        rdc(ST, 8'h02);
        spb <= 5'h08;
        send(8'hC3, 1'b0, 1'b0, 1'b1);
        wr_reg(ST, 8'h1E);
        rdc(ST, 8'h82);
        rdc(DA, 8'hC3);
        wr_reg(ST, 8'h00);
        spb <= 5'h10;
    endtask
    task automatic t_irq();
        wr_reg(CB, 8'h90);
        send(8'h66, 1'b0, 1'b0, 1'b1);
        repeat (8) begin
            chk1(irq, 1'b1);
            @(posedge clk);
        end
        rdc(DA, 8'h66);
        @(posedge clk);
        chk1(irq, 1'b0);
        send(8'h77, 1'b0, 1'b0, 1'b1);
        xmit(12'hD32, 4'hA, 1'b0);
        repeat (100) @(posedge clk);
        wr_reg(CB, 8'h00);
        repeat (2) @(posedge clk);
        chk1(pin, 1'b0);
        chk1(irq, 1'b0);
        rdc(ST, 8'h00);
        wait_idle();
        wr_reg(CB, 8'h10);
        rdc(ST, 8'h00);
    endtask
    // Reset for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_basic();
        t_fifo();
        t_parity();
        t_start();
        t_irq();
        complete_run();
    end
endmodule
bind usrx_receiver usrx_receiver_properties #(.DEPTH(DEPTH)) usrx_receiver_properties_i (
    .i_core_clk, .i_rst_n, .i_sample_tick, .i_rx_line, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_rx_irq, .o_pin_override);
